//--- hw/i2c_flag_regs_defines.vh
// register offsets, field positions and reset values for the i2c flag-clear, checksum and receive registers
// assumes a byte-addressed plain register port with 32-bit data
`ifndef I2C_FLAG_REGS_DEFINES_VH
`define I2C_FLAG_REGS_DEFINES_VH
`define ADDR_W            8
`define OFF_FLAG_CLEAR    8'h1C
`define OFF_PKT_CHECKSUM  8'h20
`define OFF_RECEIVE_BYTE  8'h24
`define OFF_STATUS        8'h18
`define OFF_IRQ_STATUS    8'h40
`define OFF_IRQ_CLEAR     8'h44
`define OFF_IRQ_ENABLE    8'h48
`define OFF_CONTROL       8'h4C
`define BIT_ALERT         13
`define BIT_TIMEOUT       12
`define BIT_CHECKSUM_ERROR_FLAG        11
`define BIT_OVERRUN       10
`define BIT_ARLOST        9
`define BIT_BUSERR        8
`define BIT_STOP          5
`define BIT_NACK          4
`define BIT_ADDR          3
`define BIT_RXFULL        2
`define FLAG_MASK         32'h00003F38
`define SMBUS_MASK        32'h00003800
`define CTL_ENABLE        0
`define CTL_CHECKSUM_EN   1
`define CTL_START         2
`define RESET_WORD        32'h00000000
`define IRQ_W             10
`endif

//--- hw/i2c_flag_regs.v
// flag-clear, packet checksum and receive byte registers of an i2c/smbus interface, plus status and interrupt
// assumes the protocol engine gives one-cycle event pulses, a received byte strobe and a checksum byte
// Overview of operation
// [R1] writing 1 to clear bit 13 clears the smbus alert flag
// [R2] writing 1 to clear bit 12 clears the timeout flag
// [R3] writing 1 to clear bit 11 clears the checksum error flag
// [R4] without smbus, clear bits 13 to 11 are reserved and forced to zero
// [R5] writing 1 to clear bit 10 clears the overrun flag
// [R6] writing 1 to clear bit 9 clears the arbitration lost flag
// [R7] writing 1 to clear bit 8 clears the bus error flag
// [R8] writing 1 to clear bit 5 clears the stop seen flag
// [R9] writing 1 to clear bit 4 clears the no acknowledge flag
// [R10] writing 1 to clear bit 3 clears the address match flag and start bit
// [R11] software writes reserved clear bits as zero
// [R12] checksum register bits 7:0 show the internal checksum byte while enabled
// [R13] checksum byte is zero whenever the interface is switched off
// [R14] without smbus the whole checksum register reads zero
// [R15] receive register bits 7:0 hold last received byte, upper bits zero
// [R16] receive full flag sets on byte arrival, clears on receive register read
// [R17] zero clear bits change nothing; the clear register reads zero
`timescale 1ns/10ps
`include "i2c_flag_regs_defines.vh"
`default_nettype none
module i2c_flag_regs #(
  parameter SMBUS_SUPPORT = 1
) (
  // clock, reset, enable
  input  wire              mclk,
  input  wire              rst,
  input  wire              clk_en,
  // register port
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // events from the protocol engine
  input  wire              ev_alert,
  input  wire              ev_timeout,
  input  wire              ev_checksum_error_flag,
  input  wire              ev_overrun,
  input  wire              ev_arlost,
  input  wire              ev_buserr,
  input  wire              ev_stop,
  input  wire              ev_nack,
  input  wire              ev_addr,
  input  wire              start_set,
  input  wire              rx_valid,
  input  wire [7:0]        rx_data,
  input  wire              checksum_load,
  input  wire [7:0]        checksum_in,
  // state towards the engine
  output wire              interface_switch_on,
  output wire              checksum_enable,
  output wire              start_request,
  output wire              receive_full_flag,
  output wire [31:0]       status_flags,
  // interrupt
  output wire              irq
);
  reg  [31:0] flags_q;
  reg         rxfull_q;
  reg  [7:0]  received_byte_q;
  reg  [7:0]  checksum_q;
  reg  [2:0]  ctl_q;
  reg  [`IRQ_W-1:0] irq_st_q;
  reg  [`IRQ_W-1:0] irq_en_q;
  wire [31:0] ev_vec;
  wire [31:0] clr_mask;
  wire [31:0] sup_mask;
  wire        wr_clear;
  wire        rd_rx;
  wire [`IRQ_W-1:0] irq_ev;
  wire [`IRQ_W-1:0] irq_clr;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // without smbus the alert/timeout/checksum bits do not exist
  assign sup_mask = (SMBUS_SUPPORT != 0) ? `FLAG_MASK : (`FLAG_MASK & ~`SMBUS_MASK); // see [R4]
  assign wr_clear = reg_wr && hit(reg_addr, `OFF_FLAG_CLEAR);
  // only ones clear; reserved bits written by software are dropped
  assign clr_mask = wr_clear ? (reg_wdata & sup_mask) : 32'h00000000; // see [R11] see [R17]
  assign rd_rx    = reg_rd && hit(reg_addr, `OFF_RECEIVE_BYTE);

  assign ev_vec = ({18'h00000, ev_alert, ev_timeout, ev_checksum_error_flag, ev_overrun, ev_arlost, ev_buserr,
                    2'b00, ev_stop, ev_nack, ev_addr, 3'b000} & sup_mask);

  assign interface_switch_on = ctl_q[`CTL_ENABLE];
  assign checksum_enable     = ctl_q[`CTL_CHECKSUM_EN];
  assign start_request       = ctl_q[`CTL_START];
  assign receive_full_flag   = rxfull_q;
  assign status_flags        = flags_q | {29'h00000000, rxfull_q, 2'b00};

  // flags: hardware set wins over a clear in the same cycle so no event is lost
  always @(posedge mclk) begin
    if (rst) begin
      flags_q <= `RESET_WORD;
    end else if (clk_en) begin
      if (!ctl_q[`CTL_ENABLE]) begin
        flags_q <= `RESET_WORD;
      end else begin
        flags_q <= (flags_q & ~clr_mask) | ev_vec; // see [R1] see [R2] see [R3] see [R5] see [R6] see [R7] see [R8] see [R9]
      end
    end
  end

  // control: enable, checksum enable, start; clearing address match also drops start
  always @(posedge mclk) begin
    if (rst) begin
      ctl_q <= 3'b000;
    end else if (clk_en) begin
      if (reg_wr && hit(reg_addr, `OFF_CONTROL)) begin
        ctl_q <= reg_wdata[2:0];
      end else if (start_set) begin
        ctl_q[`CTL_START] <= 1'b1;
      end else if (clr_mask[`BIT_ADDR]) begin
        ctl_q[`CTL_START] <= 1'b0; // see [R10]
      end
    end
  end

  // receive byte and full flag; a new byte in the read cycle keeps the flag set
  always @(posedge mclk) begin
    if (rst) begin
      received_byte_q <= 8'h00;
      rxfull_q        <= 1'b0;
    end else if (clk_en) begin
      if (rx_valid) begin
        received_byte_q <= rx_data; // see [R15]
      end
      if (!ctl_q[`CTL_ENABLE]) begin
        rxfull_q <= 1'b0;
      end else if (rx_valid) begin
        rxfull_q <= 1'b1; // see [R16]
      end else if (rd_rx) begin
        rxfull_q <= 1'b0; // see [R16]
      end
    end
  end

  // checksum byte follows the engine, zeroed while switched off
  always @(posedge mclk) begin
    if (rst) begin
      checksum_q <= 8'h00;
    end else if (clk_en) begin
      if (!ctl_q[`CTL_ENABLE]) begin
        checksum_q <= 8'h00; // see [R13]
      end else if (checksum_load && ctl_q[`CTL_CHECKSUM_EN]) begin
        checksum_q <= checksum_in; // see [R12]
      end
    end
  end

  // interrupt events: the nine flag events and receive full
  assign irq_ev  = {ev_vec[13:8], ev_vec[5:3], rx_valid & ctl_q[`CTL_ENABLE]};
  assign irq_clr = (reg_wr && hit(reg_addr, `OFF_IRQ_CLEAR)) ? reg_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  assign irq     = |(irq_st_q & irq_en_q);

  always @(posedge mclk) begin
    if (rst) begin
      irq_st_q <= {`IRQ_W{1'b0}};
      irq_en_q <= {`IRQ_W{1'b0}};
    end else if (clk_en) begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      if (reg_wr && hit(reg_addr, `OFF_IRQ_ENABLE)) begin
        irq_en_q <= reg_wdata[`IRQ_W-1:0];
      end
    end
  end

  // read data one cycle after the strobe; unmapped and write-only read zero
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= `RESET_WORD;
    end else if (clk_en) begin
      reg_rdata <= `RESET_WORD;
      if (reg_rd) begin
        case (reg_addr)
          `OFF_FLAG_CLEAR:   reg_rdata <= `RESET_WORD; // see [R17]
          `OFF_PKT_CHECKSUM: reg_rdata <= (SMBUS_SUPPORT != 0) ? {24'h000000, checksum_q} : `RESET_WORD; // see [R12] see [R14]
          `OFF_RECEIVE_BYTE: reg_rdata <= {24'h000000, received_byte_q}; // see [R15]
          `OFF_STATUS:       reg_rdata <= status_flags;
          `OFF_IRQ_STATUS:   reg_rdata <= {22'h000000, irq_st_q};
          `OFF_IRQ_ENABLE:   reg_rdata <= {22'h000000, irq_en_q};
          `OFF_CONTROL:      reg_rdata <= {29'h00000000, ctl_q};
          default:           reg_rdata <= `RESET_WORD;
        endcase
      end
    end
  end
endmodule // i2c_flag_regs
`default_nettype wire

//--- tb/i2c_flag_regs_assertions.sv
// checker for the i2c flag-clear, checksum and receive registers
// assumes it is bound to i2c_flag_regs and sees only its ports
`include "i2c_flag_regs_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module i2c_flag_regs_assertions #(parameter SMBUS_SUPPORT = 1) (
  // clock, reset, register port
  input wire logic        mclk, rst, clk_en, reg_wr, reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata, status_flags,
  // engine side and state
  input wire logic        ev_alert, ev_timeout, ev_checksum_error_flag, ev_overrun, ev_arlost, ev_buserr,
  input wire logic        ev_stop, ev_nack, ev_addr, start_set, rx_valid,
  input wire logic        interface_switch_on, start_request, receive_full_flag
);
  wire        clr = clk_en && reg_wr && reg_addr == `OFF_FLAG_CLEAR;
  wire        rd_ok = clk_en && reg_rd;
  // an event in the clear cycle wins, so its bit is left out
  wire [31:0] evv = {18'h0, ev_alert, ev_timeout, ev_checksum_error_flag, ev_overrun, ev_arlost, ev_buserr, 2'h0,
                     ev_stop, ev_nack, ev_addr, 3'h0};
  wire [31:0] kill = reg_wdata & ~evv & `FLAG_MASK;
  wire [31:0] keep = status_flags & ~reg_wdata & `FLAG_MASK;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_flag_clear:
  assert property (clr && interface_switch_on |=> (status_flags & $past(kill)) == 32'h0) else $error("flag kept");
  a_zero_keeps:
  assert property (clr && interface_switch_on |=> ($past(keep) & ~status_flags) == 32'h0) else $error("flag lost");
  a_start_clear:
  assert property (clr && reg_wdata[3] && !start_set |=> !start_request) else $error("start kept");
  a_clear_reads0:
  assert property (rd_ok && reg_addr == `OFF_FLAG_CLEAR |=> reg_rdata == 32'h0) else $error("clear reg read");
  a_rx_upper:
  assert property (rd_ok && reg_addr == `OFF_RECEIVE_BYTE |=> reg_rdata[31:8] == 24'h0) else $error("rx upper");
  a_pec_upper:
  assert property (rd_ok && reg_addr == `OFF_PKT_CHECKSUM |=> reg_rdata[31:8] == 24'h0) else $error("pec upper");
  a_pec_off:
  assert property (rd_ok && reg_addr == `OFF_PKT_CHECKSUM && !interface_switch_on && !$past(interface_switch_on)
    |=> reg_rdata == 32'h0) else $error("pec not zero");
  a_full_set:
  assert property (clk_en && rx_valid && interface_switch_on |=> receive_full_flag) else $error("full not set");
  a_full_clear:
  assert property (rd_ok && reg_addr == `OFF_RECEIVE_BYTE && !rx_valid |=> !receive_full_flag) else $error("full kept");
endmodule // i2c_flag_regs_assertions
bind i2c_flag_regs i2c_flag_regs_assertions #(.SMBUS_SUPPORT(SMBUS_SUPPORT)) u_chk (.*);
`default_nettype wire

//--- tb/i2c_engine_model.sv
// protocol engine stand-in: event pulses, received bytes, checksum bytes
// assumes the bench calls go() and mclk is the block clock
`timescale 1ns/10ps
`default_nettype none
module i2c_engine_model (
  input  wire logic       mclk,
  output logic      [8:0] ev,
  output logic            rx_valid, checksum_load,
  output logic      [7:0] rx_data, checksum_in
);
  initial {ev, rx_valid, checksum_load, rx_data, checksum_in} = {11'h0, 16'hFFFF};
  task go(input logic [8:0] e, input logic r, input logic c, input logic [7:0] b);
    @(posedge mclk);
    {ev, rx_valid, checksum_load, rx_data, checksum_in} <= {e, r, c, b, b};
    @(posedge mclk);
    // byte lines flip once the strobe drops, so a stale byte cannot pass
    {ev, rx_valid, checksum_load, rx_data, checksum_in} <= {11'h0, ~b, ~b};
  endtask
endmodule // i2c_engine_model
`default_nettype wire

//--- tb/i2c_flag_clear_pec_rx_regs_bench.sv
// bench for the i2c flag-clear, checksum and receive registers
// assumes the engine model drives events and bytes; checker comes in by bind
`include "i2c_flag_regs_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module i2c_flag_clear_pec_rx_regs_bench;
  logic mclk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, start_set = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rd_q;
  wire [31:0]  reg_rdata, status_flags;
  wire [8:0]   ev;
  wire [7:0]   rx_data, checksum_in;
  wire rx_valid, checksum_load, interface_switch_on, checksum_enable, start_request, receive_full_flag, irq;
  wire ev_alert, ev_timeout, ev_checksum_error_flag, ev_overrun, ev_arlost, ev_buserr, ev_stop, ev_nack, ev_addr;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  assign {ev_alert, ev_timeout, ev_checksum_error_flag, ev_overrun, ev_arlost, ev_buserr, ev_stop, ev_nack, ev_addr} = ev;
  i2c_engine_model m (.*);
  i2c_flag_regs i_dut (.*);
  // second build without smbus shares every input, so the reserved behaviour is seen side by side
  wire [31:0] rdata_ns, flags_ns;
  i2c_flag_regs #(.SMBUS_SUPPORT(0)) i_dut_nosmb (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_ns), .ev_alert(ev_alert), .ev_timeout(ev_timeout),
    .ev_checksum_error_flag(ev_checksum_error_flag), .ev_overrun(ev_overrun), .ev_arlost(ev_arlost), .ev_buserr(ev_buserr),
    .ev_stop(ev_stop), .ev_nack(ev_nack), .ev_addr(ev_addr), .start_set(start_set), .rx_valid(rx_valid),
    .rx_data(rx_data), .checksum_load(checksum_load), .checksum_in(checksum_in), .interface_switch_on(),
    .checksum_enable(), .start_request(), .receive_full_flag(), .status_flags(flags_ns), .irq()
  );
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 2000) begin
    error_cnt++;
    tally_and_finish;
  end
  task chk(input string n, input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task t_clear;
    logic [31:0] e;
    int bl[9];
    bl = '{13, 12, 11, 10, 9, 8, 5, 4, 3};
    e = `FLAG_MASK;
    wr(8'h4C, 32'h5);
    m.go(9'h1FF, 1'b0, 1'b0, 8'h00);
    #1 chk("flags set", status_flags, e);
    chk("flags nosmb", flags_ns, `FLAG_MASK & ~`SMBUS_MASK);
    foreach (bl[i]) begin
      wr(`OFF_FLAG_CLEAR, 32'h1 << bl[i]);
      e[bl[i]] = 1'b0;
      chk("flags", status_flags, e);
    end
    chk("start", {31'h0, start_request}, 32'h0);
    rd(`OFF_FLAG_CLEAR);
    chk("clear read", rd_q, 32'h0);
    $display("t_clear done");
  endtask
  task t_pec_rx;
    wr(8'h4C, 32'h3);
    m.go(9'h0, 1'b0, 1'b1, 8'hA5);
    rd(`OFF_PKT_CHECKSUM);
    chk("pec", rd_q, 32'hA5);
    chk("pec nosmb", rdata_ns, 32'h0);
    wr(8'h4C, 32'h0);
    rd(`OFF_PKT_CHECKSUM);
    chk("pec off", rd_q, 32'h0);
    wr(8'h4C, 32'h1);
    m.go(9'h0, 1'b1, 1'b0, 8'h5A);
    #1 chk("full", {31'h0, receive_full_flag}, 32'h1);
    rd(`OFF_RECEIVE_BYTE);
    chk("rx", rd_q, 32'h5A);
    chk("full rd", {31'h0, receive_full_flag}, 32'h0);
    $display("t_pec_rx done");
  endtask
  task t_irq;
    wr(8'h48, 32'h3FF);
    m.go(9'h002, 1'b0, 1'b0, 8'h00);
    #1 chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h48, 32'h0);
    chk("irq mask", {31'h0, irq}, 32'h0);
    wr(8'h44, 32'h3FF);
    wr(8'h48, 32'h3FF);
    chk("irq clr", {31'h0, irq}, 32'h0);
    rd(8'h30);
    chk("unmapped", rd_q, 32'h0);
    $display("t_irq done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_clear;
    t_pec_rx;
    t_irq;
    tally_and_finish;
  end
endmodule // i2c_flag_clear_pec_rx_regs_bench
`default_nettype wire
